//--- design/osc_clock_select.sv
// Purpose: oscillator control register, clock source and postscaler selection
// Assumes: oscillator pins are asynchronous to clk_i; clocks leave as enable pulses
// Notes:   internal oscillators are modelled as enable dividers of clk_i
`include "osc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - idle bit 7 set makes sleep instruction enter Idle, clear enters Sleep.
// - frequency code 111 gives fast oscillator undivided, 110 halved, 110 at reset.
// - codes 101, 100, 011 divide fast oscillator by 4, 8, 16.
// - low-freq select 1, mid select 0: codes 010/001/000 divide by 32/64/512.
// - low-freq 0, mid 1: codes 010/001 still divide by 32/64, code 000 gives slow oscillator.
// - both selects 1: code 000 gives fast oscillator divided by 512.
// - ready flag bit 3 is 1 after settle timer expires, 0 while counting.
// - ready flag reset value is the inverse of the switchover configuration bit.
// - changing the frequency code switches internal clock frequency without further action.
// - changing the source field switches the device clock source at the next edge of the old clock, at once if that is an unready primary.
// - fail-safe monitor detects primary failure and falls back to internal oscillator.
// - two-speed start runs internal oscillator until primary is ready, then changes over.
// - multiplier usable on primary or internal source, output kept at most 64 MHz.
// - low-freq select is tuning bit 7, mid select is control-2 bit 0.
// - with low-freq select 0 the lowest setting comes from slow oscillator.
// - slow oscillator runs whenever power-up, fail-safe, watchdog or two-speed is enabled.
module osc_clock_select
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        primary_osc_i,
    input  wire logic        secondary_osc_i,
    input  wire logic        switchover_config_i,
    input  wire logic        fail_monitor_en_i,
    input  wire logic        powerup_timer_en_i,
    input  wire logic        watchdog_en_i,
    input  wire logic        pll_en_i,
    input  wire logic        sleep_exec_i,
    input  wire logic        wake_i,
    output logic             cpu_clk_en_o,
    output logic             periph_clk_en_o,
    output logic             primary_osc_en_o,
    output logic             slow_osc_en_o,
    output logic             pll_active_o,
    output logic             clock_fail_o,
    output osc_pkg::osc_mode_t mode_o
);
    import osc_pkg::*;

    localparam int SETTLE_W = $clog2(`OSC_SETTLE_EDGES + 1);
    localparam int HF_W     = $clog2(`OSC_HF_STABLE_TICKS + 1);

    typedef struct packed {
        osc_mode_t            mode;
        logic                 idle_sel;
        logic [2:0]           freq;
        logic [1:0]           src;
        logic                 lfs;
        logic                 mfs;
        logic                 ready;
        logic [SETTLE_W-1:0]  settle_cnt;
        logic                 hf_stable;
        logic [HF_W-1:0]      hf_cnt;
        logic                 fail;
        logic [1:0]           fail_cnt;
        logic [2:0]           fast_div;
        logic [8:0]           ps_cnt;
        logic [8:0]           slow_cnt;
        osc_sel_t             cur;
        logic                 gap;
        logic [1:0]           sy1;
        logic [1:0]           sy2;
        logic [1:0]           last;
        logic                 tick;
        logic                 ack;
        logic [7:0]           rdata;
    } osc_state_t;

    osc_state_t s_q;
    osc_state_t s_d;

    // internal oscillator tick for a postscaler selection
    function automatic logic int_tick(input logic [2:0] code, input logic lfs, input logic mfs,
                                      input logic ft, input logic [8:0] ps, input logic st);
        logic r;
        r = 1'b0;
        unique case (code)
            3'h7: r = ft;
            3'h6: r = ft && ps[0];
            3'h5: r = ft && (&ps[1:0]);
            3'h4: r = ft && (&ps[2:0]);
            3'h3: r = ft && (&ps[3:0]);
            3'h2: r = ft && (&ps[4:0]);
            3'h1: r = ft && (&ps[5:0]);
            3'h0:
            begin
                if (lfs && mfs)
                    r = ft && (&ps[8:0]);
                else if (lfs)
                    r = ft && (&ps[8:0]);
                else
                    r = st;
            end
        endcase
        return r;
    endfunction

    logic       fast_tick;
    logic       slow_tick;
    logic       prim_edge;
    logic       sec_edge;
    logic       req;
    logic       wr;
    logic       slow_on;
    logic       two_speed;
    logic       use_internal;
    logic       old_tick;
    logic       new_tick;
    osc_sel_t   want;
    logic       cur_int;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_d       = s_q;
        req       = cyc_i && stb_i && !s_q.ack;
        wr        = req && we_i && sel_i[0];
        two_speed = switchover_config_i;
        // the old selection keeps its clock until the switch, else a change away from it hangs
        slow_on   = powerup_timer_en_i || fail_monitor_en_i || watchdog_en_i || two_speed
                    || (s_q.src[1] && s_q.freq == 3'h0 && !s_q.lfs)
                    || (s_q.cur.src[1] && s_q.cur.freq == 3'h0 && !s_q.cur.lfs);

        // only the second stage feeds the edge detectors
        s_d.sy1   = {secondary_osc_i, primary_osc_i};
        s_d.sy2   = s_q.sy1;
        s_d.last  = s_q.sy2;
        prim_edge = s_q.sy2[0] && !s_q.last[0];
        sec_edge  = s_q.sy2[1] && !s_q.last[1];

        // fast oscillator and its postscaler chain
        fast_tick  = (s_q.fast_div == 3'(`OSC_FAST_DIV - 1));
        s_d.fast_div = fast_tick ? 3'h0 : s_q.fast_div + 3'h1;
        if (fast_tick)
            s_d.ps_cnt = s_q.ps_cnt + 9'h1;
        // slow oscillator stops when nothing needs it
        slow_tick = slow_on && fast_tick && (&s_q.slow_cnt);
        if (slow_on && fast_tick)
            s_d.slow_cnt = s_q.slow_cnt + 9'h1;
        else if (!slow_on)
            s_d.slow_cnt = 9'h0;

        if (fast_tick && !s_q.hf_stable)
        begin
            s_d.hf_cnt = s_q.hf_cnt + HF_W'(1);
            if (s_q.hf_cnt == HF_W'(`OSC_HF_STABLE_TICKS - 1))
                s_d.hf_stable = 1'b1;
        end

        // settle timer counts primary edges until it runs out
        if (s_q.mode != OSC_SLEEP && !s_q.ready && prim_edge)
        begin
            s_d.settle_cnt = s_q.settle_cnt + SETTLE_W'(1);
            if (s_q.settle_cnt == SETTLE_W'(`OSC_SETTLE_EDGES - 1))
                s_d.ready = 1'b1;
        end

        // fail-safe: too many slow ticks without a primary edge
        if (fail_monitor_en_i && s_q.ready && s_q.cur.src == OSC_SRC_PRIMARY
            && s_q.mode != OSC_SLEEP && !s_q.fail)
        begin
            if (prim_edge)
                s_d.fail_cnt = 2'h0;
            else if (slow_tick)
                s_d.fail_cnt = s_q.fail_cnt + 2'h1;
            if (!prim_edge && slow_tick && s_q.fail_cnt == 2'(`OSC_FAIL_SLOW_TICKS - 1))
                s_d.fail = 1'b1;
        end
        else
        begin
            s_d.fail_cnt = 2'h0;
        end

        // register bus: ack one cycle after the request, unmapped reads give zero
        s_d.ack = req;
        if (req)
        begin
            unique case (adr_i)
                `OSC_ADR_CTRL:  s_d.rdata = {s_q.idle_sel, s_q.freq, s_q.ready, s_q.hf_stable, s_q.src};
                `OSC_ADR_TUNE:  s_d.rdata = {s_q.lfs, 7'h0};
                `OSC_ADR_CTRL2: s_d.rdata = {7'h0, s_q.mfs};
                `OSC_ADR_STAT:  s_d.rdata = {3'h0, pll_active_o, slow_on, s_q.gap, s_q.cur.src[1], s_q.fail};
                default:        s_d.rdata = 8'h0;
            endcase
        end
        if (wr)
        begin
            unique case (adr_i)
                `OSC_ADR_CTRL:
                begin
                    s_d.idle_sel = dat_i[`OSC_BIT_IDLE];
                    s_d.freq     = dat_i[`OSC_BIT_FREQ_HI:`OSC_BIT_FREQ_LO];
                    s_d.src      = dat_i[`OSC_BIT_SRC_HI:`OSC_BIT_SRC_LO];
                    // a new source clears a latched failure, but a failure seen now wins
                    if (dat_i[`OSC_BIT_SRC_HI:`OSC_BIT_SRC_LO] != s_q.src && !s_d.fail_cnt[1])
                        s_d.fail = s_d.fail && !s_q.fail;
                end
                `OSC_ADR_TUNE:  s_d.lfs = dat_i[`OSC_BIT_LFS];
                `OSC_ADR_CTRL2: s_d.mfs = dat_i[`OSC_BIT_MFS];
                default:        ;
            endcase
        end

        // power-managed modes
        unique case (s_q.mode)
            OSC_RUN:
                if (sleep_exec_i)
                    s_d.mode = s_q.idle_sel ? OSC_IDLE : OSC_SLEEP;
            OSC_IDLE:
                if (wake_i)
                    s_d.mode = OSC_RUN;
            OSC_SLEEP:
                if (wake_i)
                begin
                    s_d.mode = OSC_RUN;
                    // primary was stopped: settle again before using it
                    if (s_q.src == OSC_SRC_PRIMARY)
                    begin
                        s_d.ready      = 1'b0;
                        s_d.settle_cnt = '0;
                    end
                end
        endcase

        // effective selection: fail-safe and two-speed start override software
        use_internal = s_q.fail
                       || (s_q.src == OSC_SRC_PRIMARY && !s_q.ready && two_speed);
        want.src  = use_internal ? 2'(OSC_SRC_INTERNAL) : s_q.src;
        want.freq = s_q.freq;
        want.lfs  = s_q.lfs;
        want.mfs  = s_q.mfs;

        cur_int  = s_q.cur.src[1];
        new_tick = want.src[1] ? int_tick(want.freq, want.lfs, want.mfs, fast_tick, s_q.ps_cnt, slow_tick)
                 : (want.src == OSC_SRC_SECONDARY) ? sec_edge
                 : (s_q.ready && prim_edge);
        old_tick = cur_int ? int_tick(s_q.cur.freq, s_q.cur.lfs, s_q.cur.mfs, fast_tick, s_q.ps_cnt, slow_tick)
                 : (s_q.cur.src == OSC_SRC_SECONDARY) ? sec_edge
                 : (s_q.ready && prim_edge);

        // change over at an old edge, or at once on failure or an unready primary, then stay quiet until the new one
        s_d.tick = 1'b0;
        if (want != s_q.cur)
        begin
            if (old_tick || s_q.fail || (s_q.cur.src == OSC_SRC_PRIMARY && !s_q.ready))
            begin
                s_d.cur = want;
                s_d.gap = 1'b1;
            end
            s_d.tick = old_tick && !s_q.gap;
        end
        else if (s_q.gap)
        begin
            if (new_tick)
                s_d.gap = 1'b0;
        end
        else
        begin
            s_d.tick = old_tick;
        end

        if (rst_i)
        begin
            s_d          = '0;
            s_d.mode     = OSC_RUN;
            s_d.idle_sel = `OSC_RST_IDLE;
            s_d.freq     = `OSC_RST_FREQ;
            s_d.src      = `OSC_RST_SRC;
            s_d.lfs      = `OSC_RST_LFS;
            s_d.mfs      = `OSC_RST_MFS;
            s_d.ready    = !switchover_config_i;
            s_d.cur      = '{src: 2'(OSC_SRC_INTERNAL), freq: `OSC_RST_FREQ, lfs: `OSC_RST_LFS, mfs: `OSC_RST_MFS};
            s_d.gap      = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign dat_o            = {24'h0, s_q.rdata};
    assign ack_o            = s_q.ack;
    assign mode_o           = s_q.mode;
    assign cpu_clk_en_o     = s_q.tick && s_q.mode == OSC_RUN;
    assign periph_clk_en_o  = s_q.tick && s_q.mode != OSC_SLEEP;
    assign primary_osc_en_o = s_q.mode != OSC_SLEEP;
    assign slow_osc_en_o    = slow_on;
    assign clock_fail_o     = s_q.fail;
    // multiplier input limited to 16 MHz keeps the output at or below 64 MHz
    assign pll_active_o     = pll_en_i && (s_q.cur.src == OSC_SRC_PRIMARY
                              || (s_q.cur.src[1] && s_q.cur.freq[2:1] == 2'h3));

endmodule

//--- design/osc_defines.svh
// Purpose: constants of the oscillator control block
// Assumes: 100 MHz system clock, byte-wide registers on a 32-bit bus
// Notes:   offsets are byte addresses on the register bus
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

`define OSC_ADR_CTRL        4'h0
`define OSC_ADR_TUNE        4'h4
`define OSC_ADR_CTRL2       4'h8
`define OSC_ADR_STAT        4'hc

`define OSC_BIT_IDLE        7
`define OSC_BIT_FREQ_HI     6
`define OSC_BIT_FREQ_LO     4
`define OSC_BIT_READY       3
`define OSC_BIT_HF_STABLE   2
`define OSC_BIT_SRC_HI      1
`define OSC_BIT_SRC_LO      0
`define OSC_BIT_LFS         7
`define OSC_BIT_MFS         0

`define OSC_RST_IDLE        1'b0
`define OSC_RST_FREQ        3'h6
`define OSC_RST_SRC         2'h0
`define OSC_RST_LFS         1'b0
`define OSC_RST_MFS         1'b0

`define OSC_CLK_HZ          100000000
`define OSC_FAST_HZ         16000000
`define OSC_FAST_DIV        (`OSC_CLK_HZ / `OSC_FAST_HZ)
`define OSC_SETTLE_EDGES    1024
`define OSC_FAIL_SLOW_TICKS 2
`define OSC_HF_STABLE_TICKS 64
`define OSC_PLL_MAX_HZ      64000000

`endif

//--- design/osc_pkg.sv
// Purpose: types of the oscillator control block
// Assumes: nothing beyond the defines header
// Notes:   mode codes are one-hot
package osc_pkg;

    typedef enum logic [2:0] {
        OSC_RUN   = 3'b001,
        OSC_IDLE  = 3'b010,
        OSC_SLEEP = 3'b100
    } osc_mode_t;

    typedef enum logic [1:0] {
        OSC_SRC_PRIMARY   = 2'h0,
        OSC_SRC_SECONDARY = 2'h1,
        OSC_SRC_INTERNAL  = 2'h2,
        OSC_SRC_INT_ALT   = 2'h3
    } osc_src_t;

    typedef struct packed {
        logic [1:0] src;
        logic [2:0] freq;
        logic       lfs;
        logic       mfs;
    } osc_sel_t;

endpackage

//--- tb/osc_clock_select_asserts.sv
// Purpose: port-level checks of the oscillator control block
// Assumes: single clock domain, synchronous active-high reset
// Notes:   bound from the testbench top file
module osc_clock_select_asserts
(
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               cyc_i,
    input wire logic               stb_i,
    input wire logic               we_i,
    input wire logic [3:0]         adr_i,
    input wire logic [31:0]        dat_o,
    input wire logic               ack_o,
    input wire logic               switchover_config_i,
    input wire logic               fail_monitor_en_i,
    input wire logic               powerup_timer_en_i,
    input wire logic               watchdog_en_i,
    input wire logic               pll_en_i,
    input wire logic               sleep_exec_i,
    input wire logic               wake_i,
    input wire logic               cpu_clk_en_o,
    input wire logic               periph_clk_en_o,
    input wire logic               primary_osc_en_o,
    input wire logic               slow_osc_en_o,
    input wire logic               pll_active_o,
    input wire osc_pkg::osc_mode_t mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import osc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_sleep_cmd;
        mode_o == OSC_RUN && sleep_exec_i;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_bus_answer: assert property (s_req |=> ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i[1:0] != 2'h0 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_sleep_entry: assert property (s_sleep_cmd |=> mode_o != OSC_RUN)
        else $error("sleep command ignored");
    a_wake_run: assert property (mode_o != OSC_RUN && wake_i |=> mode_o == OSC_RUN)
        else $error("wake did not return to run");
    a_idle_cpu_off: assert property ((mode_o == OSC_IDLE) [*2] |-> !cpu_clk_en_o)
        else $error("cpu clock in idle");
    a_sleep_quiet: assert property ((mode_o == OSC_SLEEP) [*2] |->
        !cpu_clk_en_o && !periph_clk_en_o && !primary_osc_en_o)
        else $error("clocks running in sleep");
    a_slow_osc_on: assert property (fail_monitor_en_i || powerup_timer_en_i || watchdog_en_i ||
        switchover_config_i |-> slow_osc_en_o)
        else $error("slow oscillator off while needed");
    a_pll_gated: assert property (pll_active_o |-> pll_en_i)
        else $error("multiplier active without enable");
    a_pulse_gap: assert property (cpu_clk_en_o |=> !cpu_clk_en_o [*5])
        else $error("clock pulse shorter than fastest period");
endmodule

//--- tb/test_osc_clock_select.sv
// Purpose: self-checking bench of the oscillator control block
// Assumes: 100 MHz clock, classic bus master driven by this bench
// Notes:   read results go through a queue to a monitor process
module test_osc_clock_select;
    timeunit 1ns;
    timeprecision 1ps;
    import osc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic ack_o, primary_osc_i = 1'b0, secondary_osc_i = 1'b0, switchover_config_i = 1'b0;
    logic fail_monitor_en_i = 1'b0, powerup_timer_en_i = 1'b0, watchdog_en_i = 1'b0;
    logic pll_en_i = 1'b0, sleep_exec_i = 1'b0, wake_i = 1'b0, prim_run = 1'b1;
    logic cpu_clk_en_o, periph_clk_en_o, primary_osc_en_o, slow_osc_en_o, pll_active_o, clock_fail_o;
    osc_mode_t mode_o;
    logic [15:0] exp_q[$];
    logic [7:0] d;
    integer seed = 32'ha980;
    int n_mismatch = 0, n_checks = 0, i, c, k;
    osc_clock_select dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .primary_osc_i, .secondary_osc_i, .switchover_config_i, .fail_monitor_en_i,
        .powerup_timer_en_i, .watchdog_en_i, .pll_en_i, .sleep_exec_i, .wake_i, .cpu_clk_en_o,
        .periph_clk_en_o, .primary_osc_en_o, .slow_osc_en_o, .pll_active_o, .clock_fail_o, .mode_o);
    always #5 clk_i = ~clk_i;
    // oscillator pins: primary stoppable for the fail-safe case
    // primary period of six clocks, no faster than the fast internal clock
    logic [1:0] pc = 2'h0;
    always @(posedge clk_i)
    begin
        pc <= (pc == 2'h2) ? 2'h0 : pc + 2'h1;
        if (!prim_run)
            primary_osc_i <= 1'b0;
        else if (pc == 2'h2)
            primary_osc_i <= ~primary_osc_i;
        secondary_osc_i <= $random(seed);
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        n_checks++;
        if ((g & m) !== (e & m))
        begin
            n_mismatch++;
            $display("ERROR t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_rd(input logic [31:0] g, input logic [15:0] e);
        chk(g, {24'h0, e[7:0]}, {24'hffffff, e[15:8]});
    endtask
    // e = {mask, value}, only used on reads
    task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] v, input logic [15:0] e);
        if (!w)
            exp_q.push_back(e);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, v};
        @(posedge clk_i);
        for (i = 0; i < 20 && ack_o !== 1'b1; i++)
            @(posedge clk_i);
        if (ack_o !== 1'b1)
        begin
            n_mismatch++;
            stop_test();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    always @(posedge clk_i)
        if (ack_o === 1'b1 && we_i === 1'b0)
        begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0, 32'h1);
            else
                chk_rd(dat_o, exp_q.pop_front());
        end
    task automatic wp(output int n);
        n = 0;
        @(posedge clk_i);
        while (cpu_clk_en_o !== 1'b1 && n < 8000)
        begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 8000)
        begin
            n_mismatch++;
            stop_test();
        end
    endtask
    // spacing of cpu pulses, skipping the switch-over gap
    task automatic per(input int p);
        int n;
        repeat (3)
            wp(n);
        chk(n + 1, p, 32'hffff);
    endtask
    task automatic pm(input logic [7:0] ctl, input osc_mode_t m, input int np);
        int n;
        wb(4'h0, 1'b1, ctl, 16'h0);
        per(6);
        sleep_exec_i <= 1'b1;
        @(posedge clk_i);
        sleep_exec_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(mode_o, m, 32'h7);
        n = 0;
        repeat (24)
        begin
            @(posedge clk_i);
            n += periph_clk_en_o;
        end
        chk(n, np, 32'hff);
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(mode_o, OSC_RUN, 32'h7);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(4'h0, 1'b0, 8'h0, 16'hff68);
        d = $random(seed);
        wb(4'h4, 1'b1, d, 16'h0);
        wb(4'h4, 1'b0, 8'h0, {9'h1fe, d[7], 6'h0});
        wb(4'h8, 1'b1, 8'hff, 16'h0);
        wb(4'h8, 1'b0, 8'h0, 16'hff01);
        wb(4'h1, 1'b0, 8'h0, 16'hff00);
        $display("register test done");
        for (k = 1; k < 4; k++)
        begin
            wb(4'h4, 1'b1, {k[1], 7'h0}, 16'h0);
            wb(4'h8, 1'b1, {7'h0, k[0]}, 16'h0);
            for (c = 7; c >= 0; c--)
            begin
                wb(4'h0, 1'b1, {1'b0, c[2:0], 4'h2}, 16'h0);
                wb(4'h0, 1'b0, 8'h0, {8'hf3, 1'b0, c[2:0], 4'h2});
                per(c == 0 ? 3072 : 6 << (7 - c));
            end
        end
        $display("frequency test done");
        watchdog_en_i <= 1'b1;
        pm(8'hf2, OSC_IDLE, 4);
        pm(8'h72, OSC_SLEEP, 0);
        $display("power mode test done");
        powerup_timer_en_i <= 1'b1;
        fail_monitor_en_i <= 1'b1;
        wb(4'h0, 1'b1, 8'h60, 16'h0);
        // multiplier only while the code is 111 or 110 from here on
        pll_en_i <= 1'b1;
        repeat (50) @(posedge clk_i);
        prim_run <= 1'b0;
        for (i = 0; i < 10000 && clock_fail_o !== 1'b1; i++)
            @(posedge clk_i);
        chk(clock_fail_o, 1, 1);
        wb(4'hc, 1'b0, 8'h0, 16'h1b1b);
        wb(4'h0, 1'b1, 8'h62, 16'h0);
        chk(clock_fail_o, 0, 1);
        $display("fail-safe test done");
        fail_monitor_en_i <= 1'b0;
        prim_run <= 1'b1;
        switchover_config_i <= 1'b1;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(4'h0, 1'b0, 8'h0, 16'hff60);
        per(12);
        // settle needs 1024 primary edges of six clocks each
        repeat (6300) @(posedge clk_i);
        wb(4'h0, 1'b0, 8'h0, 16'h0c0c);
        per(6);
        repeat (4) @(posedge clk_i);
        $display("two-speed test done");
        stop_test();
    end
    initial
    begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end
endmodule
bind osc_clock_select osc_clock_select_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .dat_o, .ack_o, .switchover_config_i, .fail_monitor_en_i, .powerup_timer_en_i,
    .watchdog_en_i, .pll_en_i, .sleep_exec_i, .wake_i, .cpu_clk_en_o, .periph_clk_en_o,
    .primary_osc_en_o, .slow_osc_en_o, .pll_active_o, .mode_o);
